// *** hw/stp_target.sv ***
// scsi target control: self test, straps, parity, sense, reconnect, rewind
// assumes bus inputs already synchronous to core_clk and phase logic outside
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// small data fifo between host and tape side
// ****************************************************************
module stp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];  // storage words
	logic [AW-1:0]    wr_ptr_reg;       // next write slot
	logic [AW-1:0]    rd_ptr_reg;       // next read slot
	logic [AW:0]      cnt_reg;          // words held
	logic [AW:0]      cnt_next;
	logic             push;
	logic             pop;

	// handshakes on both sides
	always_comb begin
		push     = in_valid & in_ready;
		pop      = out_valid & out_ready;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	// storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// pointers, count and registered flags so ready is a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			in_ready   <= 1'b0;
			out_valid  <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (pop) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			cnt_reg   <= cnt_next;
			in_ready  <= (cnt_next != (AW+1)'(DEPTH));
			out_valid <= (cnt_next != '0);
		end
	end

	// read port; word under the read pointer
	always_comb begin
		out_data = mem_reg[rd_ptr_reg];
	end

endmodule : stp_fifo

// ****************************************************************
// target control top
// ****************************************************************
module stp_target #(
	parameter int unsigned TEST_CYC  = stp_pkg::TEST_CYC,
	parameter int unsigned BLINK_CYC = stp_pkg::BLINK_HALF_CYC,
	parameter int unsigned RECON_CYC = stp_pkg::RECON_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        scsi_rst,
	input  wire logic        bsy_in,
	input  wire logic        ack_in,
	input  wire logic        atn_in,
	input  wire logic        sel_in,
	input  wire logic [7:0]  bus_data,
	input  wire logic        bus_id_strap_bit0,
	input  wire logic        bus_id_strap_bit1,
	input  wire logic        bus_id_strap_bit2,
	input  wire logic        parity_check_disable_strap,
	input  wire logic        test_fail,
	input  wire logic        rx_valid,
	input  wire logic [1:0]  rx_kind,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_parity,
	output logic             rx_ready,
	input  wire logic        cmd_start,
	input  wire logic [15:0] blk_count,
	input  wire logic        wr_blk_end,
	input  wire logic        rd_blk_end,
	input  wire logic        tx_load,
	input  wire logic [7:0]  tx_byte,
	output logic             tx_valid_reg,
	output logic      [7:0]  tx_data_reg,
	output logic             tx_parity_reg,
	input  wire logic        arb_won,
	input  wire logic        cart_in,
	input  wire logic        rewind_done,
	input  wire logic        sense_clr,
	output logic             tape_valid,
	output logic      [7:0]  tape_data,
	input  wire logic        tape_ready,
	output logic             led_reg,
	output logic             sel_resp_reg,
	output logic      [2:0]  bus_id_reg,
	output logic      [3:0]  sense_key_reg,
	output logic             sense_b08_reg,
	output logic             sense_b09_reg,
	output logic             cmd_end_reg,
	output logic      [7:0]  status_reg,
	output logic             status_phase_reg,
	output logic             msg_phase_reg,
	output logic             blk_commit_reg,
	output logic             blk_drop_reg,
	output logic      [15:0] residue_reg,
	output logic             abort_reg,
	output logic             discard_ahead_reg,
	output logic             atn_seen_reg,
	output logic             bus_release_reg,
	output logic             reconnected_reg,
	output logic             recon_fail_reg,
	output logic             rewind_reg,
	output logic             busy_status_reg
);
	localparam int unsigned W = stp_pkg::CNT_W;

	stp_pkg::stp_test_t  test_reg;      // self test state
	stp_pkg::stp_recon_t rc_reg;        // reconnect state
	logic [W-1:0]        test_cnt_reg;  // self test timer
	logic [W-1:0]        blink_cnt_reg; // fail blink divider
	logic [W-1:0]        rc_cnt_reg;    // bsy wait timer
	logic [2:0]          cmd_cnt_reg;   // command bytes taken
	logic                cmd_perr_reg;  // id or command parity seen
	logic                wr_perr_reg;   // data out parity latched
	logic                msg_end_reg;   // message phase pending
	logic                cart_d_reg;    // cartridge level last cycle
	logic                loop_req;      // loop-on-test condition
	logic                acc;           // byte taken this cycle
	logic                bad;           // byte fails odd parity
	logic                cmd_last;      // sixth command byte
	logic                msg_perr;      // message byte with bad parity

	// odd parity check on received bytes unless strapped off
	function automatic logic par_bad(input logic [7:0] d, input logic p,
		input logic dis);
		par_bad = !dis && !(^{d, p});
	endfunction : par_bad

	// ****************************************************************
	// decode of the receive stream
	// ****************************************************************
	always_comb begin
		loop_req = ack_in && !bsy_in;
		acc      = rx_valid && rx_ready && (test_reg == stp_pkg::ST_RUN);
		bad      = acc && par_bad(rx_data, rx_parity,
			parity_check_disable_strap);
		cmd_last = acc && rx_kind == stp_pkg::KIND_CMD
			&& cmd_cnt_reg == stp_pkg::CMD_LEN - 3'h1;
		// identify carries bit 7 and counts with the command bytes
		msg_perr = bad && rx_kind == stp_pkg::KIND_MSG
			&& !rx_data[stp_pkg::IDENT_BIT];
	end

	// ****************************************************************
	// self test sequencing and led
	// ****************************************************************
	// reset, bus reset or loop condition restart the test
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			test_reg     <= stp_pkg::ST_TEST;
			test_cnt_reg <= '0;
		end else if (scsi_rst || loop_req) begin
			test_reg     <= stp_pkg::ST_TEST;
			test_cnt_reg <= '0;
		end else begin
			unique case (test_reg)
				stp_pkg::ST_TEST: begin
					// result of the test engine is taken at the end
					if (test_cnt_reg == W'(TEST_CYC - 1)) begin
						test_reg <= test_fail ? stp_pkg::ST_FAIL
							: stp_pkg::ST_RUN;
					end else begin
						test_cnt_reg <= W'(test_cnt_reg + 1'b1);
					end
				end
				stp_pkg::ST_FAIL: test_reg <= stp_pkg::ST_FAIL;
				stp_pkg::ST_RUN:  test_reg <= stp_pkg::ST_RUN;
				default:          test_reg <= stp_pkg::ST_TEST;
			endcase
		end
	end

	// led lit in test, blinking on failure, dark in service
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			led_reg       <= 1'b1;
			blink_cnt_reg <= '0;
		end else if (test_reg == stp_pkg::ST_FAIL) begin
			if (blink_cnt_reg == W'(BLINK_CYC - 1)) begin
				blink_cnt_reg <= '0;
				led_reg       <= !led_reg;
			end else begin
				blink_cnt_reg <= W'(blink_cnt_reg + 1'b1);
			end
		end else begin
			blink_cnt_reg <= '0;
			led_reg       <= (test_reg == stp_pkg::ST_TEST);
		end
	end

	// ****************************************************************
	// straps and selection
	// ****************************************************************
	// straps are read every cycle; a fitted strap reads as one
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bus_id_reg   <= 3'h0;
			sel_resp_reg <= 1'b0;
		end else begin
			bus_id_reg   <= {bus_id_strap_bit2, bus_id_strap_bit1,
				bus_id_strap_bit0};
			// no answer at all while the test runs
			sel_resp_reg <= sel_in && !bsy_in && bus_data[bus_id_reg]
				&& test_reg == stp_pkg::ST_RUN;
		end
	end

	// ****************************************************************
	// transmit parity
	// ****************************************************************
	// odd parity on every sent byte; the disable strap is not looked at
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_valid_reg  <= 1'b0;
			tx_data_reg   <= 8'h00;
			tx_parity_reg <= 1'b1;
		end else begin
			tx_valid_reg <= tx_load;
			if (tx_load) begin
				tx_data_reg   <= tx_byte;
				tx_parity_reg <= ~^tx_byte;
			end
		end
	end

	// ****************************************************************
	// command bytes and error latches
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n || cmd_start) begin
			cmd_cnt_reg  <= 3'h0;
			cmd_perr_reg <= 1'b0;
			wr_perr_reg  <= 1'b0;
		end else begin
			if (acc && rx_kind == stp_pkg::KIND_CMD) begin
				cmd_cnt_reg <= cmd_last ? 3'h0 : 3'(cmd_cnt_reg + 1'b1);
			end
			// identify or command error held until sixth byte; the
			// sixth byte's own error is used directly, so clearing
			// there leaves nothing stale for the next command
			if (cmd_last) begin
				cmd_perr_reg <= 1'b0;
			end else if (bad && rx_kind != stp_pkg::KIND_DATA
				&& !msg_perr) begin
				cmd_perr_reg <= 1'b1;
			end
			// a fresh error in the block-end cycle still counts
			if (bad && rx_kind == stp_pkg::KIND_DATA) begin
				wr_perr_reg <= 1'b1;
			end else if (wr_blk_end) begin
				wr_perr_reg <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// command ending, sense and status
	// ****************************************************************
	// sense sets win over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmd_end_reg       <= 1'b0;
			status_reg        <= stp_pkg::STATUS_GOOD;
			status_phase_reg  <= 1'b0;
			msg_phase_reg     <= 1'b0;
			msg_end_reg       <= 1'b0;
			sense_key_reg     <= stp_pkg::SENSE_NONE;
			sense_b08_reg     <= 1'b0;
			sense_b09_reg     <= 1'b0;
			abort_reg         <= 1'b0;
			discard_ahead_reg <= 1'b0;
		end else begin
			cmd_end_reg       <= 1'b0;
			status_phase_reg  <= 1'b0;
			msg_phase_reg     <= msg_end_reg;
			msg_end_reg       <= 1'b0;
			abort_reg         <= 1'b0;
			discard_ahead_reg <= 1'b0;
			if (sense_clr) begin
				sense_key_reg <= stp_pkg::SENSE_NONE;
				sense_b08_reg <= 1'b0;
				sense_b09_reg <= 1'b0;
			end
			if (cmd_last && (cmd_perr_reg || bad)) begin
				cmd_end_reg   <= 1'b1;
				status_reg    <= stp_pkg::STATUS_CHECK;
				sense_key_reg <= stp_pkg::SENSE_HW;
				sense_b08_reg <= 1'b1;
			end else if (msg_perr) begin
				// byte dropped; status then message phase follow
				status_phase_reg <= 1'b1;
				status_reg       <= stp_pkg::STATUS_CHECK;
				msg_end_reg      <= 1'b1;
				sense_key_reg    <= stp_pkg::SENSE_HW;
				sense_b09_reg    <= 1'b1;
			end else if (wr_blk_end && (wr_perr_reg || bad)) begin
				cmd_end_reg   <= 1'b1;
				status_reg    <= stp_pkg::STATUS_CHECK;
				sense_key_reg <= stp_pkg::SENSE_HW;
				sense_b09_reg <= 1'b1;
			end else if (acc && rx_kind == stp_pkg::KIND_MSG
				&& rx_data == stp_pkg::MSG_IDE) begin
				// residue is left alone so it stays valid
				abort_reg         <= 1'b1;
				discard_ahead_reg <= 1'b1;
				cmd_end_reg       <= 1'b1;
				status_reg        <= stp_pkg::STATUS_CHECK;
				sense_key_reg     <= stp_pkg::SENSE_ABORT;
			end
			if (msg_end_reg) begin
				cmd_end_reg <= 1'b1;
			end
			// a command met during rewind is answered busy
			if (cmd_start && rewind_reg) begin
				status_reg <= stp_pkg::STATUS_BUSY;
			end
		end
	end

	// ****************************************************************
	// block commit, residue and atn sampling
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			blk_commit_reg <= 1'b0;
			blk_drop_reg   <= 1'b0;
			residue_reg    <= 16'h0000;
			atn_seen_reg   <= 1'b0;
		end else begin
			blk_commit_reg <= wr_blk_end && !(wr_perr_reg || bad);
			blk_drop_reg   <= wr_blk_end && (wr_perr_reg || bad);
			if (cmd_start) begin
				residue_reg <= blk_count;
			end else if (wr_blk_end && !(wr_perr_reg || bad)
				&& residue_reg != 16'h0000) begin
				// only blocks that reach tape leave the residue
				residue_reg <= 16'(residue_reg - 1'b1);
			end
			// the host reports data-in errors only at block gaps
			atn_seen_reg <= rd_blk_end ? atn_in : 1'b0;
		end
	end

	// ****************************************************************
	// reconnect bsy wait
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rc_reg          <= stp_pkg::RC_IDLE;
			rc_cnt_reg      <= '0;
			bus_release_reg <= 1'b0;
			reconnected_reg <= 1'b0;
			recon_fail_reg  <= 1'b0;
		end else begin
			reconnected_reg <= 1'b0;
			recon_fail_reg  <= 1'b0;
			unique case (rc_reg)
				stp_pkg::RC_IDLE: begin
					// only a new arbitration win opens contact again
					if (arb_won) begin
						rc_reg          <= stp_pkg::RC_WAIT;
						rc_cnt_reg      <= '0;
						bus_release_reg <= 1'b0;
					end
				end
				stp_pkg::RC_WAIT: begin
					if (bsy_in) begin
						rc_reg          <= stp_pkg::RC_IDLE;
						reconnected_reg <= 1'b1;
					end else if (rc_cnt_reg == W'(RECON_CYC - 1)) begin
						rc_reg          <= stp_pkg::RC_CHECK;
						bus_release_reg <= 1'b1;
					end else begin
						rc_cnt_reg <= W'(rc_cnt_reg + 1'b1);
					end
				end
				stp_pkg::RC_CHECK: begin
					rc_reg          <= stp_pkg::RC_IDLE;
					reconnected_reg <= bsy_in;
					recon_fail_reg  <= !bsy_in;
				end
				default: rc_reg <= stp_pkg::RC_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// cartridge rewind and busy answer
	// ****************************************************************
	// a cartridge present at reset shows up as a rising level here
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cart_d_reg      <= 1'b0;
			rewind_reg      <= 1'b0;
			busy_status_reg <= 1'b0;
		end else begin
			cart_d_reg <= cart_in;
			if (cart_in && !cart_d_reg) begin
				rewind_reg <= 1'b1;
			end else if (rewind_done || !cart_in) begin
				rewind_reg <= 1'b0;
			end
			busy_status_reg <= cmd_start && rewind_reg;
		end
	end

	// ****************************************************************
	// data path buffer toward the tape
	// ****************************************************************
	stp_fifo #(
		.WIDTH(stp_pkg::FIFO_W),
		.DEPTH(stp_pkg::FIFO_D)
	) u_fifo (
		.clk      (core_clk),
		.rst_n    (rst_n),
		// bytes that rx_ready lets through are dropped until the self test has passed
		.in_valid (rx_valid && rx_kind == stp_pkg::KIND_DATA
			&& test_reg == stp_pkg::ST_RUN),
		.in_data  (rx_data),
		.in_ready (rx_ready),
		.out_valid(tape_valid),
		.out_data (tape_data),
		.out_ready(tape_ready)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_sel_in_test: assert property (
		test_reg != stp_pkg::ST_RUN |=> !sel_resp_reg)
		else $error("selection answered during self test");
	a_led_test_on: assert property (
		test_reg == stp_pkg::ST_TEST ##1 test_reg == stp_pkg::ST_TEST
		|-> led_reg)
		else $error("led dark during self test");
	a_loop_restart: assert property (
		loop_req |=> test_reg == stp_pkg::ST_TEST && test_cnt_reg == '0)
		else $error("loop condition did not restart test");
	a_tx_odd_par: assert property (
		tx_valid_reg |-> ^{tx_data_reg, tx_parity_reg})
		else $error("sent byte without odd parity");
	a_cmd_perr_end: assert property (
		cmd_last && (cmd_perr_reg || bad) |=> cmd_end_reg && sense_b08_reg
		&& sense_key_reg == stp_pkg::SENSE_HW)
		else $error("command parity error not reported");
	a_wr_blk_drop: assert property (
		wr_blk_end && wr_perr_reg && !cmd_start |=> blk_drop_reg
		&& !blk_commit_reg && $stable(residue_reg))
		else $error("bad write block recorded");
	a_msg_perr_seq: assert property (
		msg_perr && !cmd_last |=> status_phase_reg
		&& status_reg == stp_pkg::STATUS_CHECK ##1 msg_phase_reg
		&& cmd_end_reg)
		else $error("message parity sequence wrong");
	a_recon_expire: assert property (
		rc_reg == stp_pkg::RC_WAIT && !bsy_in
		&& rc_cnt_reg == W'(RECON_CYC - 1) |=> bus_release_reg
		##1 (recon_fail_reg || reconnected_reg))
		else $error("reconnect timeout not handled");
	a_rewind_busy: assert property (
		cmd_start && rewind_reg |=> busy_status_reg
		&& status_reg == stp_pkg::STATUS_BUSY)
		else $error("command not answered busy in rewind");

	c_test_pass: cover property (
		test_reg == stp_pkg::ST_TEST ##1 test_reg == stp_pkg::ST_RUN);
	c_recon_fail: cover property (recon_fail_reg);
	c_fifo_full: cover property (rx_valid && !rx_ready);
	c_msg_perr: cover property (msg_perr);

endmodule : stp_target

`default_nettype wire

// *** hw/stp_pkg.sv ***
// constants and types for the scsi target parity and reconnect block
// assumes a single 50 MHz core clock; no bus, every control bit is a port
package stp_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_HZ        = 50_000_000;  // core clock rate
	localparam int unsigned TEST_MS       = 300;         // self test length
	localparam int unsigned TEST_CYC      = CLK_HZ / 1000 * TEST_MS;
	localparam int unsigned BLINK_HZ      = 4;           // fail blink rate
	localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned RECON_MS      = 250;         // reconnect wait
	localparam int unsigned RECON_CYC     = CLK_HZ / 1000 * RECON_MS;
	localparam int unsigned CNT_W         = 24;          // timer width

	// ****************************************************************
	// protocol values
	// ****************************************************************
	localparam logic [2:0] CMD_LEN      = 3'h6;   // bytes in a command block
	localparam logic [3:0] SENSE_NONE   = 4'h0;   // no sense
	localparam logic [3:0] SENSE_HW     = 4'h4;   // hardware error
	localparam logic [3:0] SENSE_ABORT  = 4'hB;   // command aborted
	localparam logic [7:0] STATUS_GOOD  = 8'h00;  // good status
	localparam logic [7:0] STATUS_CHECK = 8'h02;  // check condition
	localparam logic [7:0] STATUS_BUSY  = 8'h08;  // busy
	localparam logic [7:0] MSG_IDE      = 8'h05;  // initiator detected error
	localparam int unsigned IDENT_BIT   = 7;      // identify message flag
	localparam logic [1:0] KIND_MSG     = 2'h0;   // message out byte
	localparam logic [1:0] KIND_CMD     = 2'h1;   // command byte
	localparam logic [1:0] KIND_DATA    = 2'h2;   // data out byte
	localparam int unsigned FIFO_W      = 8;      // data path width
	localparam int unsigned FIFO_D      = 4;      // data path depth
	localparam int unsigned RES_W       = 16;     // residue width

	// ****************************************************************
	// state types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_TEST = 2'b00,
		ST_FAIL = 2'b01,
		ST_RUN  = 2'b10
	} stp_test_t;

	typedef enum logic [1:0] {
		RC_IDLE  = 2'b00,
		RC_WAIT  = 2'b01,
		RC_CHECK = 2'b10
	} stp_recon_t;

endpackage : stp_pkg

// *** sim/stp_host_model.sv ***
// host initiator model: hands the target one byte per request
// assumes the bench pulses h_go once and waits for rx_valid to fall
`timescale 1ns/1ns
`default_nettype none
module stp_host_model (
	input  wire logic       core_clk,
	input  wire logic       rx_ready,
	input  wire logic       h_go,
	input  wire logic       h_bad,
	input  wire logic [1:0] h_kind,
	input  wire logic [7:0] h_data,
	output logic            rx_valid = 1'h0,
	output logic            rx_parity = 1'h1,
	output logic      [1:0] rx_kind = 2'h0,
	output logic      [7:0] rx_data = 8'h00
);
	// byte held until the edge that sees ready; released data inverted
	// so a stale byte never passes for a fresh one
	always @(posedge core_clk) begin
		if (h_go && !rx_valid) begin
			rx_valid <= 1'h1;
			rx_kind <= h_kind;
			rx_data <= h_data;
			rx_parity <= ~^h_data ^ h_bad;
		end else if (rx_valid && rx_ready) begin
			rx_valid <= 1'h0;
			rx_data <= ~rx_data;
		end
	end
endmodule : stp_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
// bench for the scsi target block, by sequences of pulses and bytes
// assumes stp_pkg, stp_target and stp_host_model compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// signals carry the port names so instances connect by name
	logic core_clk = 0, rst_n = 0, scsi_rst = 0, bsy_in = 0, ack_in = 0;
	logic atn_in = 0, sel_in = 0, test_fail = 0, cmd_start = 0, clr = 0;
	logic wr_blk_end = 0, rd_blk_end = 0, tx_load = 0, arb_won = 0;
	logic cart_in = 0, rewind_done = 0, sense_clr = 0, tape_ready = 1;
	logic bus_id_strap_bit0 = 1, bus_id_strap_bit1 = 0, h_go = 0, h_bad = 0;
	logic bus_id_strap_bit2 = 1, parity_check_disable_strap = 0;
	logic [7:0] bus_data = 0, tx_byte = 0, h_data = 0;
	logic [15:0] blk_count = 0;
	logic [1:0] h_kind = 0, rx_kind;
	logic rx_valid, rx_parity, rx_ready, tx_valid_reg, tx_parity_reg;
	logic tape_valid, led_reg, sel_resp_reg, sense_b08_reg, sense_b09_reg;
	logic cmd_end_reg, status_phase_reg, msg_phase_reg, blk_commit_reg;
	logic blk_drop_reg, abort_reg, discard_ahead_reg, atn_seen_reg;
	logic bus_release_reg, reconnected_reg, recon_fail_reg, rewind_reg;
	logic busy_status_reg;
	logic [7:0] rx_data, tx_data_reg, tape_data, status_reg;
	logic [2:0] bus_id_reg;
	logic [3:0] sense_key_reg;
	logic [15:0] residue_reg;
	logic [9:0] seen = 0;  // sticky pulses, so no exact cycle is guessed
	int num_errors = 0, n_checks = 0, tmo = 0;

	stp_target #(.TEST_CYC(20), .BLINK_CYC(4), .RECON_CYC(10))
		i_stp_target (.*);
	stp_host_model i_stp_host_model (.*);

	initial forever #10 core_clk = ~core_clk;
	always @(posedge core_clk) seen <= clr ? '0 : seen | {sel_resp_reg,
		cmd_end_reg, status_phase_reg, msg_phase_reg, blk_commit_reg,
		blk_drop_reg, abort_reg, atn_seen_reg, recon_fail_reg,
		busy_status_reg};
	// hang guard, well above the run length
	always @(posedge core_clk) if (++tmo == 3000) begin
		num_errors++;
		give_verdict;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : cyc
	task automatic pls(ref logic s);
		s = 1;
		cyc(1);
		s = 0;
	endtask : pls
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic snd(input logic [1:0] k, input logic [7:0] d, input bit b);
		h_kind = k;
		h_data = d;
		h_bad = b;
		pls(h_go);
		for (int i = 0; i < 20 && rx_valid; i++) cyc(1);
	endtask : snd
	task give_verdict;
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	initial begin
		sel_in = 1;
		bus_data = 8'h20;
		cyc(5);
		chk("led", led_reg, 1'h1);
		rst_n = 1;
		cyc(3);
		chk("id", bus_id_reg, 3'h5);
		chk("sel_test", seen[9], 1'h0);
		cyc(25);
		chk("sel_run", seen[9], 1'h1);
		sel_in = 0;
		tx_byte = 8'h00;
		pls(tx_load);
		chk("par0", tx_parity_reg, 1'h1);
		for (int i = 0; i < 6; i++) begin
			if (i == 5) chk("end5", seen[8], 1'h0);
			snd(2'h1, 8'h12, i == 0);
		end
		cyc(2);
		chk("end6", seen[8], 1'h1);
		chk("key8", {sense_key_reg, sense_b08_reg}, 5'h09);
		parity_check_disable_strap = 1;
		pls(sense_clr);
		pls(cmd_start);
		for (int i = 0; i < 6; i++) snd(2'h1, 8'h00, 1);
		tx_byte = 8'h01;
		pls(tx_load);
		chk("par1", {tx_valid_reg, tx_data_reg, tx_parity_reg}, 10'h202);
		chk("dis", {sense_key_reg, sense_b08_reg}, 5'h00);
		parity_check_disable_strap = 0;
		pls(clr);
		snd(2'h0, 8'h01, 1);
		cyc(3);
		chk("msg", {seen[7:6], sense_b09_reg, status_reg}, 11'h702);
		chk("key9", sense_key_reg, 4'h4);
		pls(sense_clr);
		tape_ready = 0;
		for (int i = 0; i < 4; i++) snd(2'h2, 8'(i), 0);
		chk("full", {rx_ready, tape_valid, tape_data}, 10'h100);
		tape_ready = 1;
		blk_count = 16'h0003;
		pls(cmd_start);
		snd(2'h2, 8'h55, 0);
		pls(wr_blk_end);
		cyc(1);
		chk("commit", {seen[5], residue_reg}, 17'h10002);
		snd(2'h2, 8'hAA, 1);
		pls(wr_blk_end);
		cyc(1);
		chk("drop", {seen[4], sense_b09_reg, residue_reg}, 18'h30002);
		pls(sense_clr);
		snd(2'h0, 8'h05, 0);
		chk("ahead", discard_ahead_reg, 1'h1);
		cyc(2);
		chk("abort", {seen[3], sense_key_reg}, 5'h1B);
		atn_in = 1;
		pls(rd_blk_end);
		cyc(1);
		chk("atn", seen[2], 1'h1);
		pls(arb_won);
		cyc(7);
		chk("wait", bus_release_reg, 1'h0);
		cyc(7);
		chk("fail", {bus_release_reg, seen[1]}, 2'h3);
		bsy_in = 1;
		pls(arb_won);
		cyc(1);
		chk("recon", {bus_release_reg, reconnected_reg}, 2'h1);
		bsy_in = 0;
		cart_in = 1;
		cyc(2);
		pls(cmd_start);
		cyc(1);
		chk("busy", {rewind_reg, seen[0], status_reg}, 10'h308);
		pls(rewind_done);
		cyc(1);
		chk("rewound", rewind_reg, 1'h0);
		test_fail = 1;
		pls(scsi_rst);
		cyc(30);
		h_bad = led_reg;
		cyc(4);
		chk("blink", led_reg, !h_bad);
		test_fail = 0;
		ack_in = 1;
		cyc(30);
		pls(clr);
		pls(sel_in);
		cyc(2);
		chk("loop", seen[9], 1'h0);
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
